// ==== rtl/sdl_pkg.sv ====
// constants and types for the segment / digital-io pin mux and display driver
package sdl_pkg;
    localparam int NUM_SHARED      = 32;
    localparam int NUM_DEDICATED   = 5;
    localparam int NUM_SEG_PINS    = NUM_SHARED + NUM_DEDICATED;
    localparam int NUM_COMS        = 6;
    localparam int SEGS_PER_PIN    = 6;
    localparam int NUM_ROUTED      = 10;
    localparam int ROUTE_FIRST_PIN = 2;
    localparam int FIFTH_COM_PIN   = 27;
    localparam int SIXTH_COM_PIN   = 26;
    localparam int BLINK_PIN_A     = 22;
    localparam int BLINK_PIN_B     = 23;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] ADDR_SEG_MAP  = 16'h2400;
    localparam logic [15:0] ADDR_DIO_DIR  = 16'h2404;
    localparam logic [15:0] ADDR_DIO_OUT  = 16'h2408;
    localparam logic [15:0] ADDR_CTRL     = 16'h240C;
    localparam logic [15:0] ADDR_DIO_IN   = 16'h2410;
    localparam logic [15:0] ADDR_TRIM     = 16'h2414;
    localparam logic [15:0] ADDR_STATUS   = 16'h2418;
    localparam logic [15:0] ADDR_SEG_DATA = 16'h2500;

    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_ALL_ON_BIT  = 1;
    localparam int CTRL_CLEAR_BIT   = 2;
    localparam int CTRL_COMS_LSB    = 3;
    localparam int CTRL_BIAS_LSB    = 6;
    localparam int CTRL_RATE_BIT    = 8;
    localparam int TRIM_DAC_LSB     = 0;
    localparam int TRIM_BLINK_A_LSB = 8;
    localparam int TRIM_BLINK_B_LSB = 16;
    localparam int STAT_PB_BIT      = 0;
    localparam int STAT_COM_LSB     = 1;
    localparam int STAT_PHASE_BIT   = 4;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [2:0]  COMS_RESET  = 3'h4;
    localparam logic [2:0]  COMS_MIN    = 3'h1;
    localparam logic [2:0]  COMS_MAX    = 3'h6;
    localparam logic [4:0]  DAC_RESET   = 5'h00;
    localparam logic [5:0]  BLINK_RESET = 6'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_NS       = 4;
    localparam int SLOT_TIME_NS        = 1000000;
    localparam int SLOT_TIME_MS        = 1;
    localparam int SLOT_CYCLES_DEFAULT = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int BLINK_FAST_HALF_MS  = 500;
    localparam int BLINK_SLOW_HALF_MS  = 1000;
    localparam logic [9:0] BLINK_FAST_SLOTS = 10'(BLINK_FAST_HALF_MS / SLOT_TIME_MS);
    localparam logic [9:0] BLINK_SLOW_SLOTS = 10'(BLINK_SLOW_HALF_MS / SLOT_TIME_MS);

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        SDL_BIAS_STATIC = 2'h0,
        SDL_BIAS_HALF   = 2'h1,
        SDL_BIAS_THIRD  = 2'h2
    } sdl_bias_t;

    typedef enum logic [1:0] {
        SDL_DRV_SEG_OFF   = 2'h0,
        SDL_DRV_SEG_ON    = 2'h1,
        SDL_DRV_COM_SEL   = 2'h2,
        SDL_DRV_COM_DESEL = 2'h3
    } sdl_drive_t;

    typedef struct packed {
        logic      blink_slow;
        sdl_bias_t bias;
        logic [2:0] com_count;
        logic      all_on;
        logic      enable;
    } sdl_cfg_t;
endpackage : sdl_pkg

// ==== rtl/sdl_top.sv ====
// shared segment / digital-io pins and multiplexed display driver with axi4-lite registers
`timescale 1ns/1ps
module sdl_top #(
    parameter logic [17:0] SLOT_CYCLES = 18'(sdl_pkg::SLOT_CYCLES_DEFAULT)
) (
    // clock and reset
    input  wire  logic                                        clk,
    input  wire  logic                                        reset,
    // axi4-lite write
    input  wire  logic [15:0]                                 s_axi_awaddr,
    input  wire  logic                                        s_axi_awvalid,
    output logic                                              s_axi_awready,
    input  wire  logic [31:0]                                 s_axi_wdata,
    input  wire  logic [3:0]                                  s_axi_wstrb,
    input  wire  logic                                        s_axi_wvalid,
    output logic                                              s_axi_wready,
    output logic [1:0]                                        s_axi_bresp,
    output logic                                              s_axi_bvalid,
    input  wire  logic                                        s_axi_bready,
    // axi4-lite read
    input  wire  logic [15:0]                                 s_axi_araddr,
    input  wire  logic                                        s_axi_arvalid,
    output logic                                              s_axi_arready,
    output logic [31:0]                                       s_axi_rdata,
    output logic [1:0]                                        s_axi_rresp,
    output logic                                              s_axi_rvalid,
    input  wire  logic                                        s_axi_rready,
    // shared pins, io side
    input  wire  logic [sdl_pkg::NUM_SHARED-1:0]              shared_segment_io_in,
    output logic [sdl_pkg::NUM_SHARED-1:0]                    shared_segment_io_out,
    output logic [sdl_pkg::NUM_SHARED-1:0]                    shared_segment_io_oe,
    input  wire  logic                                        pushbutton_input,
    // routing to interrupt controller and timers
    output logic [sdl_pkg::NUM_ROUTED:0]                      event_route,
    // display drive
    output sdl_pkg::sdl_drive_t [sdl_pkg::NUM_SEG_PINS-1:0]   seg_drive,
    output sdl_pkg::sdl_drive_t [3:0]                         com_drive,
    output sdl_pkg::sdl_bias_t                                bias_mode,
    output logic [4:0]                                        bias_trim_dac,
    output logic                                              dac_power_en
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0]        segment_select_map;
    logic [31:0]        dio_dir;
    logic [31:0]        dio_out;
    sdl_pkg::sdl_cfg_t  cfg;
    logic [5:0]         blink_map_pin_a;
    logic [5:0]         blink_map_pin_b;
    logic [5:0]         segment_data_regs [0:sdl_pkg::NUM_SEG_PINS-1];
    logic [17:0]        slot_cnt;
    logic [2:0]         com_idx;
    logic [9:0]         blink_cnt;
    logic               blink_phase;
    logic               slot_end;
    logic               aw_held;
    logic               w_held;
    logic [15:0]        wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    logic               wr_fire;
    logic               wr_hit;
    logic               wr_data_hit;
    logic [5:0]         wr_idx;
    logic               display_data_clear;
    logic [31:0]        next_rdata;
    logic               rd_hit;
    logic [5:0]         rd_idx;
    logic [31:0]        lcd_pin;
    logic [31:0]        next_ctrl;
    logic [31:0]        next_trim;
    sdl_pkg::sdl_drive_t [sdl_pkg::NUM_SEG_PINS-1:0] next_seg_drive;
    sdl_pkg::sdl_drive_t [sdl_pkg::NUM_COMS-1:0]     next_com;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic [2:0] clamp_coms(input logic [2:0] v);
        if (v < sdl_pkg::COMS_MIN) begin
            return sdl_pkg::COMS_MIN;
        end
        if (v > sdl_pkg::COMS_MAX) begin
            return sdl_pkg::COMS_MAX;
        end
        return v;
    endfunction : clamp_coms

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order, answer after both
    assign wr_fire     = aw_held & w_held;
    assign wr_idx      = 6'((wr_addr - sdl_pkg::ADDR_SEG_DATA) >> 2);
    assign wr_data_hit = (wr_addr >= sdl_pkg::ADDR_SEG_DATA) && (wr_addr[1:0] == 2'h0)
                         && ((wr_addr - sdl_pkg::ADDR_SEG_DATA) < 16'(4 * sdl_pkg::NUM_SEG_PINS));
    assign wr_hit      = wr_data_hit || (wr_addr == sdl_pkg::ADDR_SEG_MAP) || (wr_addr == sdl_pkg::ADDR_DIO_DIR)
                         || (wr_addr == sdl_pkg::ADDR_DIO_OUT) || (wr_addr == sdl_pkg::ADDR_CTRL)
                         || (wr_addr == sdl_pkg::ADDR_DIO_IN) || (wr_addr == sdl_pkg::ADDR_TRIM)
                         || (wr_addr == sdl_pkg::ADDR_STATUS);
    // pulse only; the bit never stores, so it reads back as zero
    assign display_data_clear = wr_fire && (wr_addr == sdl_pkg::ADDR_CTRL) && wr_strb[0]
                                && wr_data[sdl_pkg::CTRL_CLEAR_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= sdl_pkg::RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 16'h0000;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
        end else begin
            if (!aw_held && !w_held && !s_axi_bvalid && !s_axi_awready && !s_axi_wready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_held       <= 1'b1;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_held       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? sdl_pkg::RESP_OKAY : sdl_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers
    assign next_ctrl = merge({23'h000000, cfg.blink_slow, cfg.bias, cfg.com_count, 1'b0, cfg.all_on, cfg.enable},
                             wr_data, wr_strb);
    assign next_trim = merge({10'h000, blink_map_pin_b, 2'h0, blink_map_pin_a, 3'h0, bias_trim_dac},
                             wr_data, wr_strb);

    always_ff @(posedge clk) begin
        if (reset) begin
            segment_select_map <= 32'h00000000;
            dio_dir            <= 32'h00000000;
            dio_out            <= 32'h00000000;
        end else if (wr_fire) begin
            if (wr_addr == sdl_pkg::ADDR_SEG_MAP) begin
                segment_select_map <= merge(segment_select_map, wr_data, wr_strb);
            end
            if (wr_addr == sdl_pkg::ADDR_DIO_DIR) begin
                dio_dir <= merge(dio_dir, wr_data, wr_strb);
            end
            if (wr_addr == sdl_pkg::ADDR_DIO_OUT) begin
                dio_out <= merge(dio_out, wr_data, wr_strb);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg.enable      <= 1'b0;
            cfg.all_on      <= 1'b0;
            cfg.com_count   <= sdl_pkg::COMS_RESET;
            cfg.bias        <= sdl_pkg::SDL_BIAS_THIRD;
            cfg.blink_slow  <= 1'b0;
            blink_map_pin_a <= sdl_pkg::BLINK_RESET;
            blink_map_pin_b <= sdl_pkg::BLINK_RESET;
            bias_trim_dac   <= sdl_pkg::DAC_RESET;
            dac_power_en    <= 1'b0;
        end else if (wr_fire) begin
            if (wr_addr == sdl_pkg::ADDR_CTRL) begin
                cfg.enable     <= next_ctrl[sdl_pkg::CTRL_ENABLE_BIT];
                cfg.all_on     <= next_ctrl[sdl_pkg::CTRL_ALL_ON_BIT];
                cfg.com_count  <= clamp_coms(next_ctrl[sdl_pkg::CTRL_COMS_LSB +: 3]);
                cfg.bias       <= (next_ctrl[sdl_pkg::CTRL_BIAS_LSB +: 2] == 2'h3) ? sdl_pkg::SDL_BIAS_THIRD
                                  : sdl_pkg::sdl_bias_t'(next_ctrl[sdl_pkg::CTRL_BIAS_LSB +: 2]);
                cfg.blink_slow <= next_ctrl[sdl_pkg::CTRL_RATE_BIT];
            end
            if (wr_addr == sdl_pkg::ADDR_TRIM) begin
                blink_map_pin_a <= next_trim[sdl_pkg::TRIM_BLINK_A_LSB +: 6];
                blink_map_pin_b <= next_trim[sdl_pkg::TRIM_BLINK_B_LSB +: 6];
                bias_trim_dac   <= next_trim[sdl_pkg::TRIM_DAC_LSB +: 5];
                dac_power_en    <= next_trim[sdl_pkg::TRIM_DAC_LSB +: 5] != 5'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // segment data: six bits per pin, bit n lights the segment on common n
    generate
        for (genvar i = 0; i < sdl_pkg::NUM_SEG_PINS; i++) begin : g_data
            always_ff @(posedge clk) begin
                if (reset) begin
                    segment_data_regs[i] <= 6'h00;
                end else if (display_data_clear && (i >= sdl_pkg::NUM_SHARED || segment_select_map[i])) begin
                    segment_data_regs[i] <= 6'h00;
                end else if (wr_fire && wr_data_hit && wr_idx == 6'(i) && wr_strb[0]) begin
                    segment_data_regs[i] <= wr_data[5:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // common scan and blink timebase
    assign slot_end = (slot_cnt == SLOT_CYCLES - 18'h00001);

    always_ff @(posedge clk) begin
        if (reset) begin
            slot_cnt <= 18'h00000;
            com_idx  <= 3'h0;
        end else if (slot_end) begin
            slot_cnt <= 18'h00000;
            com_idx  <= (com_idx + 3'h1 >= cfg.com_count) ? 3'h0 : com_idx + 3'h1;
        end else begin
            slot_cnt <= slot_cnt + 18'h00001;
        end
    end

    // the half period counts whole slots, so the rate is exact only while slot length is default
    always_ff @(posedge clk) begin
        if (reset) begin
            blink_cnt   <= 10'h000;
            blink_phase <= 1'b0;
        end else if (slot_end) begin
            if (blink_cnt + 10'h001 >= (cfg.blink_slow ? sdl_pkg::BLINK_SLOW_SLOTS : sdl_pkg::BLINK_FAST_SLOTS)) begin
                blink_cnt   <= 10'h000;
                blink_phase <= ~blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // drive levels for every display pin
    always_comb begin
        logic on;
        on = 1'b0;
        for (int j = 0; j < sdl_pkg::NUM_COMS; j++) begin
            if (3'(j) >= cfg.com_count) begin
                next_com[j] = sdl_pkg::SDL_DRV_SEG_OFF;
            end else begin
                next_com[j] = (3'(j) == com_idx) ? sdl_pkg::SDL_DRV_COM_SEL : sdl_pkg::SDL_DRV_COM_DESEL;
            end
        end
        for (int i = 0; i < sdl_pkg::NUM_SEG_PINS; i++) begin
            on = segment_data_regs[i][com_idx];
            if (i == sdl_pkg::BLINK_PIN_A && blink_phase && blink_map_pin_a[com_idx]) begin
                on = 1'b0;
            end
            if (i == sdl_pkg::BLINK_PIN_B && blink_phase && blink_map_pin_b[com_idx]) begin
                on = 1'b0;
            end
            // masking the output only, so stored data survives blank and all-on
            if (!cfg.enable) begin
                on = 1'b0;
            end else if (cfg.all_on) begin
                on = 1'b1;
            end
            next_seg_drive[i] = on ? sdl_pkg::SDL_DRV_SEG_ON : sdl_pkg::SDL_DRV_SEG_OFF;
            if (i < sdl_pkg::NUM_SHARED && !lcd_pin[i]) begin
                next_seg_drive[i] = sdl_pkg::SDL_DRV_SEG_OFF;
            end
        end
        if (cfg.com_count >= 3'h5) begin
            next_seg_drive[sdl_pkg::FIFTH_COM_PIN] = next_com[4];
        end
        if (cfg.com_count >= 3'h6) begin
            next_seg_drive[sdl_pkg::SIXTH_COM_PIN] = next_com[5];
        end
    end

    // a pin taken over as a common is a display pin whatever its map bit says
    always_comb begin
        lcd_pin = segment_select_map;
        if (cfg.com_count >= 3'h5) begin
            lcd_pin[sdl_pkg::FIFTH_COM_PIN] = 1'b1;
        end
        if (cfg.com_count >= 3'h6) begin
            lcd_pin[sdl_pkg::SIXTH_COM_PIN] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            seg_drive <= '{default: sdl_pkg::SDL_DRV_SEG_OFF};
            com_drive <= '{default: sdl_pkg::SDL_DRV_SEG_OFF};
            bias_mode <= sdl_pkg::SDL_BIAS_THIRD;
        end else begin
            seg_drive <= next_seg_drive;
            com_drive <= next_com[3:0];
            bias_mode <= cfg.bias;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // io pins and event routing
    always_ff @(posedge clk) begin
        if (reset) begin
            shared_segment_io_out <= 32'h00000000;
            shared_segment_io_oe  <= 32'h00000000;
            event_route           <= 11'h000;
        end else begin
            shared_segment_io_out <= dio_out;
            shared_segment_io_oe  <= dio_dir & ~lcd_pin;
            for (int k = 0; k < sdl_pkg::NUM_ROUTED; k++) begin
                event_route[k] <= shared_segment_io_oe[k + sdl_pkg::ROUTE_FIRST_PIN]
                                  ? shared_segment_io_out[k + sdl_pkg::ROUTE_FIRST_PIN]
                                  : shared_segment_io_in[k + sdl_pkg::ROUTE_FIRST_PIN];
            end
            event_route[sdl_pkg::NUM_ROUTED] <= pushbutton_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address to data
    assign rd_idx = 6'((s_axi_araddr - sdl_pkg::ADDR_SEG_DATA) >> 2);

    always_comb begin
        rd_hit     = 1'b1;
        next_rdata = 32'h00000000;
        unique case (s_axi_araddr)
            sdl_pkg::ADDR_SEG_MAP: next_rdata = segment_select_map;
            sdl_pkg::ADDR_DIO_DIR: next_rdata = dio_dir;
            sdl_pkg::ADDR_DIO_OUT: next_rdata = dio_out;
            sdl_pkg::ADDR_CTRL:    next_rdata = {23'h000000, cfg.blink_slow, cfg.bias, cfg.com_count, 1'b0,
                                                 cfg.all_on, cfg.enable};
            sdl_pkg::ADDR_DIO_IN:  next_rdata = shared_segment_io_in;
            sdl_pkg::ADDR_TRIM:    next_rdata = {10'h000, blink_map_pin_b, 2'h0, blink_map_pin_a, 3'h0, bias_trim_dac};
            sdl_pkg::ADDR_STATUS:  next_rdata = {27'h0000000, blink_phase, com_idx, pushbutton_input};
            default: begin
                if (s_axi_araddr >= sdl_pkg::ADDR_SEG_DATA && s_axi_araddr[1:0] == 2'h0
                    && (s_axi_araddr - sdl_pkg::ADDR_SEG_DATA) < 16'(4 * sdl_pkg::NUM_SEG_PINS)) begin
                    next_rdata = {26'h0000000, segment_data_regs[rd_idx]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= sdl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_hit ? sdl_pkg::RESP_OKAY : sdl_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : sdl_top

// ==== testbench/sdl_properties.sv ====
// port assertions for the pin mux and display driver
`timescale 1ns/1ps
module sdl_properties (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins
    input wire logic pushbutton_input,
    input wire logic [31:0] shared_segment_io_in,
    input wire logic [31:0] shared_segment_io_out,
    input wire logic [31:0] shared_segment_io_oe,
    input wire logic [10:0] event_route,
    // display
    input wire sdl_pkg::sdl_drive_t [36:0] seg_drive,
    input wire sdl_pkg::sdl_bias_t bias_mode,
    input wire logic [4:0] bias_trim_dac,
    input wire logic dac_power_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    reset_clear_a: assert property (disable iff (1'h0) reset |=> shared_segment_io_oe == '0 && !dac_power_en)
        else $error("pins or dac left on by reset");
    dac_power_a: assert property (dac_power_en == (bias_trim_dac != 5'h00))
        else $error("dac power does not follow trim");
    pb_route_a: assert property (!$past(reset, 2) |-> event_route[10] == $past(pushbutton_input))
        else $error("pushbutton route wrong");
    pin_route_a: assert property (!$past(reset, 2) |-> event_route[9:0] == $past((shared_segment_io_oe[11:2]
        & shared_segment_io_out[11:2]) | (~shared_segment_io_oe[11:2] & shared_segment_io_in[11:2])))
        else $error("pin route wrong");
    // only the entry is checked, though oe and scan drive settle in the same cycle on exit as well
    fifth_com_a: assert property ($rose(seg_drive[27][1]) |-> !shared_segment_io_oe[27])
        else $error("fifth common pin still driven as io");
    sixth_com_a: assert property ($rose(seg_drive[26][1]) |-> !shared_segment_io_oe[26] && seg_drive[27][1])
        else $error("sixth common without fifth or io drive");
    dedicated_seg_a: assert property (!seg_drive[36][1] && !seg_drive[32][1])
        else $error("segment-only pin carries a common");
    bias_code_a: assert property (bias_mode != 2'h3)
        else $error("illegal bias scheme");
endmodule : sdl_properties
bind sdl_top sdl_properties u_props (.*);

// ==== testbench/sdl_glass.sv ====
// display glass and board pull model
`timescale 1ns/1ps
module sdl_glass (
    // board and glass side
    input wire sdl_pkg::sdl_drive_t [36:0] seg_drive,
    input wire logic [31:0] oe,
    input wire logic [31:0] out,
    input wire logic [31:0] pull,
    output logic [31:0] pin_in,
    output logic [36:0] lit
);
    // undriven pins settle at the board pull level, never the last value
    assign pin_in = (oe & out) | (~oe & pull);
    always_comb begin
        for (int i = 0; i < 37; i++) begin
            lit[i] = seg_drive[i] == sdl_pkg::SDL_DRV_SEG_ON;
        end
    end
endmodule : sdl_glass

// ==== testbench/sdl_top_tb.sv ====
// self-checking bench for the pin mux and display driver
`timescale 1ns/1ps
module sdl_top_tb;
    logic clk = 1'h0, reset = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pushbutton_input = 1'h1, s;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, pull = 32'h800, shared_segment_io_in, shared_segment_io_out, q;
    logic [31:0] shared_segment_io_oe, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dac_power_en;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [10:0] event_route;
    logic [4:0] bias_trim_dac;
    logic [36:0] lit;
    sdl_pkg::sdl_drive_t [36:0] seg_drive;
    sdl_pkg::sdl_drive_t [3:0] com_drive;
    sdl_pkg::sdl_bias_t bias_mode;
    int error_cnt = 0, n_compared = 0;
    sdl_top #(.SLOT_CYCLES(18'h4)) DUT (.*);
    sdl_glass glass (.seg_drive(seg_drive), .oe(shared_segment_io_oe), .out(shared_segment_io_out),
        .pull(pull), .pin_in(shared_segment_io_in), .lit(lit));
    initial forever #2 clk = ~clk;
    ////////////////////////////////////////
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one write or read; bready/rready held from the start until the answer
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid || s_axi_rvalid) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        if (i == 50) begin
            error_cnt++;
            $display("Error at %0t: timeout %h %h", $time, a, d);
            end_of_test;
        end
    endtask : xfer
    // a full scan at six commons of four-cycle slots is 24 cycles
    task automatic see(input int p);
        s = 1'h0;
        repeat (40) begin
            @(posedge clk);
            s = s | lit[p];
        end
    endtask : see
    ////////////////////////////////////////
    task automatic t_regs;
        chk(shared_segment_io_oe, 32'h0);
        xfer(1'h0, 16'h240C, 32'h0);
        chk(q, 32'hA0);
        xfer(1'h0, 16'h2600, 32'h0);
        chk(32'(r), 32'h2);
        xfer(1'h1, 16'h2404, 32'h0400_0004);
        xfer(1'h1, 16'h2408, 32'h4);
        repeat (3) @(posedge clk);
        chk(shared_segment_io_oe, 32'h0400_0004);
        chk(32'(event_route), 32'h601);
        pushbutton_input <= 1'h0;
        xfer(1'h0, 16'h2410, 32'h0);
        chk(q, 32'h804);
        chk(32'(event_route[10]), 32'h0);
        xfer(1'h1, 16'h2400, 32'h4);
        repeat (3) @(posedge clk);
        chk(shared_segment_io_oe, 32'h0400_0000);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_display;
        xfer(1'h1, 16'h2400, 32'h20);
        xfer(1'h1, 16'h2590, 32'h3F);
        xfer(1'h1, 16'h2514, 32'h3F);
        xfer(1'h1, 16'h250C, 32'h15);
        xfer(1'h1, 16'h240C, 32'hA0);
        see(36);
        chk(32'(s), 32'h0);
        xfer(1'h1, 16'h240C, 32'hA1);
        see(36);
        chk(32'(s), 32'h1);
        xfer(1'h1, 16'h240C, 32'hA5);
        xfer(1'h0, 16'h2590, 32'h0);
        chk(q, 32'h0);
        xfer(1'h0, 16'h2514, 32'h0);
        chk(q, 32'h0);
        xfer(1'h0, 16'h250C, 32'h0);
        chk(q, 32'h15);
        xfer(1'h1, 16'h240C, 32'hA3);
        see(36);
        chk(32'(s), 32'h1);
        $display("t_display done");
    endtask : t_display
    task automatic t_coms;
        xfer(1'h1, 16'h240C, 32'hB1);
        repeat (30) @(posedge clk);
        chk({seg_drive[26][1], shared_segment_io_oe[26]}, 32'h2);
        xfer(1'h1, 16'h240C, 32'hA9);
        repeat (30) @(posedge clk);
        chk({seg_drive[27][1], seg_drive[26][1]}, 32'h2);
        for (int b = 0; b < 3; b++) begin
            xfer(1'h1, 16'h240C, 32'h21 | 32'(b << 6));
            repeat (2) @(posedge clk);
            chk(32'(bias_mode), 32'(b));
        end
        xfer(1'h1, 16'h2400, 32'h0040_0020);
        xfer(1'h1, 16'h2558, 32'h3F);
        xfer(1'h1, 16'h2414, 32'h3F00);
        q = 32'h0;
        // two fast half periods of 500 four-cycle slots: lit for about half of them
        repeat (16'h1004) begin
            @(posedge clk);
            q = q + 32'(lit[22]);
        end
        chk(32'(q > 32'h3E8 && q < 32'hC1C), 32'h1);
        xfer(1'h1, 16'h240C, 32'h91);
        repeat (2) @(posedge clk);
        chk(32'({com_drive[3:2], com_drive[0][1]}), 32'h1);
        xfer(1'h1, 16'h2414, 32'hA);
        chk({dac_power_en, bias_trim_dac}, 32'h2A);
        xfer(1'h1, 16'h2414, 32'h0);
        chk({dac_power_en, bias_trim_dac}, 32'h0);
        $display("t_coms done");
    endtask : t_coms
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        t_regs;
        t_display;
        t_coms;
        end_of_test;
    end
endmodule : sdl_top_tb
